/* File: hw/pwm_pkg.sv */
// Shared constants, types and helpers for the fan and LED pulse generator.
// Assumes a single 20 MHz clock and a synchronous active-high reset.
//
// Behaviour
// R1 - High-phase length n gives an ON phase of n+1 pulse clock ticks.
// R2 - High length zero with nonzero low length holds the output at full off.
// R3 - Output toggles, holds constantly on, or holds constantly off by lengths.
// R4 - Toggling drives ON for the high count, then OFF for the low count.
// R5 - Pulse clock source is fast or slow by bit 1, then prescaled.
// R6 - Period is (prescale+1) times (high+1 plus low+1) source ticks.
// R7 - Software should access the two length registers as 16-bit values.
// R8 - Length writes land in holding registers, not in the values in use.
// R9 - Holding values move to active only when full and the low phase ends; while stopped the code moves a full set at once.
// R10 - In full-on state a full holding set moves to active at once.
// R11 - Each transfer empties the holding set; all bytes must be rewritten.
// R12 - Length reads return the active values, never the holding values.
// R13 - Sleep request zeroes the counters and forces state and output off.
// R14 - System reset restores all defaults; high length resets to zero.
// R15 - The generator raises no interrupt or event signal at all.
// R16 - Low length n gives n+1 OFF ticks; zero holds full on; resets to ones.
// R17 - Polarity bit 2 set makes the ON phase drive the pin low.
// R18 - Clearing enable bit 0 resets counters, state off, output inactive.
// R19 - Prescale field p divides the selected source by p+1; zero is bypass.
// R20 - Enabling starts a period with the ON phase loaded from high length.
package pwm_pkg;

  // ****************************************************************
  // Clocking
  // ****************************************************************
  localparam int CLK_HZ      = 20_000_000;
  localparam int SLOW_SRC_HZ = 100_000;
  localparam logic [7:0] SLOW_DIV_LAST = 8'(CLK_HZ / SLOW_SRC_HZ - 1);

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [7:0]  OFS_HIGH  = 8'h00;
  localparam logic [7:0]  OFS_LOW   = 8'h04;
  localparam logic [7:0]  OFS_SETUP = 8'h08;
  localparam int          SETUP_W   = 7;
  localparam logic [15:0] HIGH_RST  = 16'h0000;
  localparam logic [15:0] LOW_RST   = 16'hffff;
  localparam logic [SETUP_W-1:0] SETUP_RST = 7'h00;

  // Setup register, bit for bit: prescale 6:3, polarity 2, source 1, enable 0.
  typedef struct packed {
    logic [3:0] pre;
    logic       inv;
    logic       clk_sel;
    logic       en;
  } setup_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } reg_req_s;

  typedef enum logic [1:0] {ST_OFF, ST_ON, ST_LOW} phase_e;

  typedef struct packed {
    phase_e      ph;
    logic [15:0] cnt;
    logic [15:0] high_act;
    logic [15:0] low_act;
    setup_s      setup;
    logic [7:0]  slow_cnt;
    logic        slow_tick;
    logic        pwm;
    logic [31:0] rd_data;
  } gen_state_s;

  typedef struct packed {
    logic [15:0] high;
    logic [15:0] low;
    logic [1:0]  got;
  } hold_state_s;

  typedef struct packed {
    logic [3:0] cnt;
  } pre_state_s;

  // Pin level for a given logical ON state and polarity.
  function automatic logic pin_level(input logic on, input logic inv);
    return on ^ inv;
  endfunction

endpackage

/* File: hw/pwm_prescaler.sv */
// Prescaler that turns source ticks into pulse clock ticks.
// Assumes source ticks are one-cycle enables on the same clock.
`timescale 1ns/1ps
`default_nettype none
module pwm_prescaler (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_src_tick,
  input  wire logic [3:0] i_div,
  input  wire logic       i_clr,
  output var  logic       o_tick
);
  import pwm_pkg::*;

  pre_state_s r;
  pre_state_s r_nxt;

  // A tick leaves on the source tick that closes each group of div+1. The
  // at-least compare lets a smaller divisor written mid-count take hold at once.
  assign o_tick = i_src_tick && (r.cnt >= i_div) && !i_clr; // R19

  // Clearing keeps the first phase aligned to the moment of enable.
  always_comb begin
    r_nxt = r;
    if (i_clr) begin
      r_nxt.cnt = 4'h0;
    end else if (i_src_tick) begin
      r_nxt.cnt = (r.cnt >= i_div) ? 4'h0 : r.cnt + 4'h1; // R19
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_pre_bypass: assert property ((i_div == 4'h0 && i_src_tick && !i_clr) |-> o_tick) // R19
    else $error("Prescale zero did not pass a source tick.");
  a_pre_halve: assert property (((o_tick && i_div == 4'h1) ##1 (i_div == 4'h1)) |-> !o_tick) // R19
    else $error("Prescale one gave ticks back to back.");

endmodule // pwm_prescaler
`default_nettype wire

/* File: hw/pwm_hold_regs.sv */
// Holding registers for the two phase lengths, with a fill tracker.
// Assumes write strobes are one cycle and come from the register decode.
`timescale 1ns/1ps
`default_nettype none
module pwm_hold_regs (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_wr_high,
  input  wire logic        i_wr_low,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_take,
  output var  logic [15:0] o_high,
  output var  logic [15:0] o_low,
  output var  logic        o_full
);
  import pwm_pkg::*;

  hold_state_s r;
  hold_state_s r_nxt;

  assign o_high = r.high;
  assign o_low  = r.low;
  assign o_full = &r.got;

  // A word write fills both bytes of a length; a write in the take cycle wins.
  always_comb begin
    r_nxt = r;
    if (i_take) begin
      r_nxt.got = 2'b00; // R11
    end
    if (i_wr_high) begin
      r_nxt.high   = i_wdata; // R8 R7
      r_nxt.got[0] = 1'b1;
    end
    if (i_wr_low) begin
      r_nxt.low    = i_wdata; // R8
      r_nxt.got[1] = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r <= {HIGH_RST, LOW_RST, 2'b00};
    end else begin
      r <= r_nxt;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_hold_empties: assert property ((i_take && !i_wr_high && !i_wr_low) |=> !o_full) // R11
    else $error("Holding set stayed full after a transfer.");
  a_hold_needs_both: assert property ((r.got == 2'b00 && i_wr_high && !i_wr_low) |=> !o_full) // R11
    else $error("Holding set reported full after one length.");

endmodule // pwm_hold_regs
`default_nettype wire

/* File: hw/fan_led_pwm_generator.sv */
// Pulse-width generator for fans and LEDs: registers, phase counter, pin.
// Assumes a register master on i_clk and a sleep request on the same clock.
`timescale 1ns/1ps
`default_nettype none
module fan_led_pwm_generator (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire pwm_pkg::reg_req_s i_req,
  input  wire logic              i_sleep_req,
  output var  logic [31:0]       o_rd_data,
  output var  logic              o_pwm_out
);
  import pwm_pkg::*;

  // ****************************************************************
  // State and helper nets
  // ****************************************************************
  gen_state_s  r;
  gen_state_s  r_nxt;
  logic        run;
  logic        src_tick;
  logic        tick;
  logic        low_end;
  logic        xfer;
  logic        wr_high;
  logic        wr_low;
  logic        hold_full;
  logic [15:0] hold_high;
  logic [15:0] hold_low;
  logic        phase_on;

  // Sleep overrides enable; both stop the counter the same way.
  assign run = r.setup.en && !i_sleep_req; // R13 R18

  // The fast source runs at the full system rate, the slow one from a divider.
  assign src_tick = r.setup.clk_sel ? r.slow_tick : 1'b1; // R5

  // Length writes go to the holding set; setup is written directly.
  assign wr_high = i_req.wr && (i_req.addr == OFS_HIGH);
  assign wr_low  = i_req.wr && (i_req.addr == OFS_LOW);

  // The low phase is over on the tick that finds its counter at zero.
  assign low_end = run && (r.ph == ST_LOW) && (r.low_act != 16'h0000) && tick
                   && (r.cnt == 16'h0000); // R9

  // Outside a running count a full holding set is taken at once, since no
  // low phase will ever end to release it.
  // While toggling, the transfer waits for the last tick of the OFF phase,
  // so a period is never built from one old and one new length.
  assign xfer = hold_full && (!run || (r.low_act == 16'h0000) || low_end); // R9 R10

  // Logical ON state, before polarity is applied.
  assign phase_on = run && ((r.low_act == 16'h0000) ||
                    ((r.high_act != 16'h0000) && (r.ph == ST_ON))); // R2 R3 R16

  assign o_rd_data = r.rd_data;
  // The pin and read data are the only outputs; nothing signals an event.
  assign o_pwm_out = r.pwm; // R15

  // ****************************************************************
  // Sub-blocks
  // ****************************************************************
  pwm_prescaler u_prescaler (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_src_tick (src_tick),
    .i_div      (r.setup.pre),
    .i_clr      (!run),
    .o_tick     (tick)
  );

  pwm_hold_regs u_hold (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_wr_high (wr_high),
    .i_wr_low  (wr_low),
    .i_wdata   (i_req.wdata[15:0]),
    .i_take    (xfer),
    .o_high    (hold_high),
    .o_low     (hold_low),
    .o_full    (hold_full)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    r_nxt = r;

    // Slow source divider; it free-runs so the slow rate is always ready.
    r_nxt.slow_tick = 1'b0;
    if (r.slow_cnt == SLOW_DIV_LAST) begin
      r_nxt.slow_cnt  = 8'h00;
      r_nxt.slow_tick = 1'b1; // R5
    end else begin
      r_nxt.slow_cnt = r.slow_cnt + 8'h01;
    end

    // Active lengths change only through a transfer from the holding set.
    if (xfer) begin
      r_nxt.high_act = hold_high; // R9 R10
      r_nxt.low_act  = hold_low;
    end

    // The setup register takes software writes directly.
    if (i_req.wr && (i_req.addr == OFS_SETUP)) begin
      r_nxt.setup = setup_s'(i_req.wdata[SETUP_W-1:0]); // R17 R19
    end

    // Phase counter. Each phase counts from its length down to zero, so a
    // length of n lasts n+1 ticks and a period is the sum of both.
    // With high 1, low 2 and no prescale: one cycle in OFF after enable,
    // ON holds counts 1 and 0, LOW holds 2, 1 and 0, then ON again.
    // A zero low length is decided first, so it beats a zero high length
    // and the pin stays on.
    // Full off keeps the counter stepping, because only the end of an
    // OFF phase releases a waiting transfer while running.
    // Trade-off: a length change never cuts a period short.
    if (!run) begin
      r_nxt.ph  = ST_OFF; // R13 R18
      r_nxt.cnt = 16'h0000;
    end else begin
      case (r.ph)
        ST_OFF: begin
          r_nxt.ph  = ST_ON; // R20
          r_nxt.cnt = r.high_act;
        end
        ST_ON: begin
          if (r.low_act == 16'h0000) begin
            r_nxt.cnt = r.high_act; // R16
          end else if (tick) begin
            if (r.cnt == 16'h0000) begin
              r_nxt.ph  = ST_LOW; // R4 R1
              r_nxt.cnt = r.low_act;
            end else begin
              r_nxt.cnt = r.cnt - 16'h0001; // R6
            end
          end
        end
        ST_LOW: begin
          if (r.low_act == 16'h0000) begin
            r_nxt.ph  = ST_ON;
            r_nxt.cnt = r.high_act;
          end else if (tick) begin
            if (r.cnt == 16'h0000) begin
              // A new period starts from the freshly transferred length.
              r_nxt.ph  = ST_ON; // R4 R16
              r_nxt.cnt = xfer ? hold_high : r.high_act;
            end else begin
              r_nxt.cnt = r.cnt - 16'h0001; // R6
            end
          end
        end
        default: begin
          r_nxt.ph  = ST_OFF;
          r_nxt.cnt = 16'h0000;
        end
      endcase
    end

    // Pin level is registered so the output never glitches on decode.
    r_nxt.pwm = pin_level(phase_on, r.setup.inv); // R17 R18 R13

    // Reads show the lengths in use, not what is waiting to be loaded.
    r_nxt.rd_data = 32'h0000_0000;
    if (i_req.rd) begin
      case (i_req.addr)
        OFS_HIGH:  r_nxt.rd_data = {16'h0000, r.high_act}; // R12
        OFS_LOW:   r_nxt.rd_data = {16'h0000, r.low_act}; // R12
        OFS_SETUP: r_nxt.rd_data = {25'h0, r.setup};
        default:   r_nxt.rd_data = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      // Fields with a non-zero default are laid over a cleared state.
      r          <= '0; // R14
      r.ph       <= ST_OFF;
      r.high_act <= HIGH_RST;
      r.low_act  <= LOW_RST; // R16
      r.setup    <= setup_s'(SETUP_RST);
    end else begin
      r <= r_nxt;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // A period is followed step by step: OFF for one cycle, then ON and LOW
  // each count down once per tick.
  // The pin is registered, so pin checks look one cycle after the state
  // that decides the level.
  // Active lengths change only through the holding set.
  // All checks except a_reset_defaults rest while reset is high, so a reset
  // in mid-period restarts them cleanly.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_on_done;
    run && (r.ph == ST_ON) && (r.low_act != 16'h0000) && tick && (r.cnt == 16'h0000);
  endsequence

  sequence s_low_done_idle;
    low_end && !hold_full;
  endsequence

  sequence s_low_done_take;
    low_end && hold_full;
  endsequence

  sequence s_on_step;
    run && (r.ph == ST_ON) && (r.low_act != 16'h0000) && tick && (r.cnt != 16'h0000);
  endsequence

  sequence s_low_step;
    run && (r.ph == ST_LOW) && (r.low_act != 16'h0000) && tick && (r.cnt != 16'h0000);
  endsequence

  sequence s_waiting;
    run && (r.ph != ST_OFF) && (r.low_act != 16'h0000) && !tick;
  endsequence

  property p_reset_defaults;
    @(posedge i_clk) disable iff (1'b0)
      i_rst |=> (r.high_act == HIGH_RST) && (r.low_act == LOW_RST) && !r.setup.en;
  endproperty

  a_reset_defaults: assert property (p_reset_defaults) // R14
    else $error("Registers did not return to their defaults after reset.");

  a_on_to_low: assert property (s_on_done |=> (r.ph == ST_LOW) && (r.cnt == $past(r.low_act))) // R4
    else $error("ON phase did not hand over to the OFF phase.");

  a_low_to_on: assert property (s_low_done_idle |=> (r.ph == ST_ON)
                                && (r.cnt == $past(r.high_act))) // R1
    else $error("OFF phase did not start a new ON phase.");

  a_low_end_xfer: assert property (s_low_done_take |=> (r.high_act == $past(hold_high))
                                   && (r.cnt == $past(hold_high)) && !hold_full) // R9
    else $error("Holding set not loaded at the end of the OFF phase.");

  a_fullon_xfer: assert property ((run && r.low_act == 16'h0000 && hold_full)
                                  |=> (r.low_act == $past(hold_low))) // R10
    else $error("Full-on state did not load the holding set at once.");

  a_hold_isolated: assert property ((wr_high && !hold_full) |=> $stable(r.high_act)) // R8
    else $error("A length write changed the active value directly.");

  a_full_off: assert property ((run && r.high_act == 16'h0000 && r.low_act != 16'h0000)
                               |=> (o_pwm_out == $past(r.setup.inv))) // R2
    else $error("Zero high length did not hold the pin off.");

  a_full_on: assert property ((run && r.low_act == 16'h0000)
                              |=> (o_pwm_out == !$past(r.setup.inv))) // R16
    else $error("Zero low length did not hold the pin on.");

  a_disable_off: assert property (!r.setup.en |=> (r.ph == ST_OFF) && (r.cnt == 16'h0000)
                                  && (o_pwm_out == $past(r.setup.inv))) // R18
    else $error("Disabled generator did not go to its inactive state.");

  a_sleep_off: assert property ((r.setup.en && i_sleep_req) |=> (r.ph == ST_OFF)
                                && (r.cnt == 16'h0000) && (o_pwm_out == $past(r.setup.inv))) // R13
    else $error("Sleep request did not force the generator off.");

  a_enable_start: assert property ((run && r.ph == ST_OFF) |=> (r.ph == ST_ON)
                                   && (r.cnt == $past(r.high_act))) // R20
    else $error("Enable did not start with the ON phase.");

  a_read_active: assert property ((i_req.rd && i_req.addr == OFS_HIGH)
                                  |=> (o_rd_data == {16'h0000, $past(r.high_act)})) // R12
    else $error("High length read did not return the active value.");

  a_on_polarity: assert property ((run && r.ph == ST_ON && r.high_act != 16'h0000)
                                  |=> (o_pwm_out == !$past(r.setup.inv))) // R17
    else $error("ON phase drove the wrong pin level.");

  // Counting steps: one count per tick, and nothing moves between ticks.
  a_on_step: assert property (s_on_step |=> (r.ph == ST_ON)
                              && (r.cnt == $past(r.cnt) - 16'h0001)) // R1
    else $error("ON phase count did not step down by one on a tick.");

  a_low_step: assert property (s_low_step |=> (r.ph == ST_LOW)
                               && (r.cnt == $past(r.cnt) - 16'h0001)) // R6
    else $error("OFF phase count did not step down by one on a tick.");

  a_wait_tick: assert property (s_waiting |=> $stable(r.cnt) && $stable(r.ph)) // R6
    else $error("Phase counter moved without a pulse clock tick.");

  a_low_level: assert property ((run && r.ph == ST_LOW && r.low_act != 16'h0000)
                                |=> (o_pwm_out == $past(r.setup.inv))) // R4
    else $error("OFF phase drove the wrong pin level.");

  a_full_on_stays: assert property ((run && r.low_act == 16'h0000 && !hold_full)
                                    |=> (r.ph == ST_ON)) // R3
    else $error("Full-on state left the ON phase.");

  // Pulse clock: the slow source ticks once in 200 clocks, the fast one
  // every clock, and a stopped generator sees no ticks at all.
  a_slow_period: assert property (r.slow_tick |-> ##200 r.slow_tick) // R5
    else $error("Slow source tick came at the wrong spacing.");

  a_fast_bypass: assert property ((run && !r.setup.clk_sel && r.setup.pre == 4'h0)
                                  |-> tick) // R5
    else $error("Fast source without prescale missed a tick.");

  a_stopped_tick: assert property (!run |-> !tick) // R18
    else $error("A stopped generator still saw pulse clock ticks.");

  // Length transfers: only a full holding set moves, and moving empties it.
  a_low_isolated: assert property ((wr_low && !hold_full) |=> $stable(r.low_act)) // R8
    else $error("A low length write changed the active value directly.");

  a_active_steady: assert property (!xfer |=> $stable(r.high_act)
                                    && $stable(r.low_act)) // R9
    else $error("Active lengths changed without a transfer.");

  a_xfer_empties: assert property ((xfer && !wr_high && !wr_low) |=> !hold_full) // R11
    else $error("Holding set still full after a transfer.");

  // Register reads and the setup write; read data stand for one cycle only.
  a_read_low: assert property ((i_req.rd && i_req.addr == OFS_LOW)
                               |=> (o_rd_data == {16'h0000, $past(r.low_act)})) // R12
    else $error("Low length read did not return the active value.");

  a_read_setup: assert property ((i_req.rd && i_req.addr == OFS_SETUP)
                                 |=> (o_rd_data == {25'h0, $past(r.setup)})) // R17
    else $error("Setup read did not return the stored fields.");

  a_read_idle: assert property (!i_req.rd |=> (o_rd_data == 32'h0000_0000)) // R12
    else $error("Read data stood for longer than one cycle.");

  a_setup_write: assert property ((i_req.wr && i_req.addr == OFS_SETUP)
                                  |=> (r.setup == $past(i_req.wdata[SETUP_W-1:0]))) // R5
    else $error("Setup write did not land in the setup fields.");

endmodule // fan_led_pwm_generator
`default_nettype wire

/* File: testbench/pwm_load_model.sv */
// Load on the pulse pin, such as a fan or an LED, measuring each high and low run.
// Assumes the pin is a registered level on the same clock as the bench.
`timescale 1ns/1ps
`default_nettype none
module pwm_load_model (
  input  wire logic        i_clk,
  input  wire logic        i_pin,
  output var  logic [15:0] o_hi_w,
  output var  logic [15:0] o_lo_w,
  output var  logic [15:0] o_edges
);
  logic        last_r  = 1'b0;
  logic [15:0] run_r   = 16'h0000;
  logic [15:0] hi_r    = 16'h0000;
  logic [15:0] lo_r    = 16'h0000;
  logic [15:0] edges_r = 16'h0000;

  // A run closes at the first edge that sees the other level, so widths are in clocks.
  always @(posedge i_clk) begin
    last_r <= i_pin;
    if (i_pin !== last_r) begin
      run_r   <= 16'h0001;
      edges_r <= edges_r + 16'h0001;
      if (last_r === 1'b1) begin
        hi_r <= run_r;
      end else begin
        lo_r <= run_r;
      end
    end else begin
      run_r <= run_r + 16'h0001;
    end
  end

  // The load only listens, so it drives nothing back toward the pin.
  assign o_hi_w  = hi_r;
  assign o_lo_w  = lo_r;
  assign o_edges = edges_r;
endmodule // pwm_load_model
`default_nettype wire

/* File: testbench/test_fan_led_pwm_generator.sv */
// Self-checking bench for the pulse generator: register tasks and pin measurements.
// Assumes the design package is compiled first and the load model beside it.
`timescale 1ns/1ps
`default_nettype none
module test_fan_led_pwm_generator;
  import pwm_pkg::*;
  logic        clk = 1'b0;
  logic        rst;
  logic        sleep;
  reg_req_s    req;
  logic [31:0] rd_data;
  logic        pwm;
  logic [15:0] hi_w;
  logic [15:0] lo_w;
  logic [15:0] edges;
  int          failures  = 0;
  int          tests_run = 0;

  fan_led_pwm_generator fan_led_pwm_generator_inst (
    .i_clk(clk), .i_rst(rst), .i_req(req), .i_sleep_req(sleep),
    .o_rd_data(rd_data), .o_pwm_out(pwm));
  pwm_load_model pwm_load_model_inst (
    .i_clk(clk), .i_pin(pwm), .o_hi_w(hi_w), .o_lo_w(lo_w), .o_edges(edges));

  // ****************************************************************
  // Clock, compare and closing
  // ****************************************************************
  // A 50 ns period gives the 20 MHz system clock.
  initial forever #25 clk = ~clk;

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // Register bus and pin tasks
  // ****************************************************************
  // One-cycle write strobe; the slave never stalls, so no wait is needed.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req.wr    <= 1'b1;
    req.addr  <= a;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just after that edge.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    @(posedge clk);
    req.rd   <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    #1 check(name, exp, rd_data);
  endtask

  // Waits for n pin edges, bounded, then checks the latest high and low run widths.
  task automatic measure(input int n, input logic [15:0] hi, input logic [15:0] lo,
                         input string name);
    logic [15:0] e0;
    int          t;
    e0 = edges;
    t  = 0;
    while (int'(edges - e0) < n && t < 20000) begin
      @(posedge clk);
      t++;
    end
    #1 check({name, " high run"}, {16'h0, hi}, {16'h0, hi_w});
    check({name, " low run"}, {16'h0, lo}, {16'h0, lo_w});
  endtask

  // Counts cycles in which the pin leaves the expected steady level.
  task automatic hold(input logic lvl, input int n, input string name);
    int bad;
    bad = 0;
    repeat (n) begin
      @(posedge clk);
      #1 if (pwm !== lvl) bad++;
    end
    check(name, 32'h0, 32'(bad));
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  // Whole run is under 8000 cycles; the watchdog allows far more before calling a hang.
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    $display("mismatch watchdog expected done seen hang");
    tally_and_finish();
  end

  // Scenarios run in order; each leaves the generator in a known setup for the next.
  initial begin
    rst   = 1'b1;
    sleep = 1'b0;
    req   = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_HIGH, 32'h0000_0000, "high reset");
    rd(OFS_LOW, 32'h0000_ffff, "low reset");
    rd(OFS_SETUP, 32'h0000_0000, "setup reset");
    check("pin reset", 32'h0, {31'h0, pwm});
    wr(8'h0c, 32'hffff_ffff);
    rd(8'h0c, 32'h0000_0000, "unmapped read");
    wr(OFS_HIGH, 32'h0000_0001);
    rd(OFS_HIGH, 32'h0000_0000, "high pending");
    wr(OFS_LOW, 32'h0000_0002);
    repeat (3) @(posedge clk);
    rd(OFS_HIGH, 32'h0000_0001, "high active");
    rd(OFS_LOW, 32'h0000_0002, "low active");
    @(posedge clk);
    #1 check("read idle", 32'h0, rd_data);
    wr(OFS_SETUP, 32'h0000_0001);
    measure(6, 16'd2, 16'd3, "toggle");
    check("toggle period", 32'd5, 32'(hi_w + lo_w));
    wr(OFS_SETUP, 32'h0000_0009);
    measure(6, 16'd4, 16'd6, "prescaled");
    check("prescaled period", 32'd10, 32'(hi_w + lo_w));
    wr(OFS_SETUP, 32'h0000_0001);
    wr(OFS_HIGH, 32'h0000_0003);
    rd(OFS_HIGH, 32'h0000_0001, "high held");
    wr(OFS_LOW, 32'h0000_0004);
    measure(6, 16'd4, 16'd5, "updated");
    wr(OFS_HIGH, 32'h0000_0007);
    measure(6, 16'd4, 16'd5, "half set");
    rd(OFS_HIGH, 32'h0000_0003, "half set high");
    wr(OFS_LOW, 32'h0000_0004);
    measure(6, 16'd8, 16'd5, "second set");
    wr(OFS_SETUP, 32'h0000_0005);
    measure(6, 16'd5, 16'd8, "inverted");
    wr(OFS_SETUP, 32'h0000_0001);
    wr(OFS_HIGH, 32'h0000_0001);
    wr(OFS_LOW, 32'h0000_0000);
    repeat (40) @(posedge clk);
    hold(1'b1, 30, "full on");
    wr(OFS_HIGH, 32'h0000_0000);
    wr(OFS_LOW, 32'h0000_0005);
    repeat (3) @(posedge clk);
    rd(OFS_HIGH, 32'h0000_0000, "full on update");
    repeat (3) @(posedge clk);
    hold(1'b0, 30, "full off");
    wr(OFS_HIGH, 32'h0000_0002);
    wr(OFS_LOW, 32'h0000_0003);
    measure(6, 16'd3, 16'd4, "after off");
    @(posedge clk);
    sleep <= 1'b1;
    repeat (2) @(posedge clk);
    hold(1'b0, 20, "asleep");
    @(posedge clk);
    sleep <= 1'b0;
    measure(3, 16'd3, 16'd4, "wake");
    wr(OFS_SETUP, 32'h0000_0004);
    repeat (3) @(posedge clk);
    hold(1'b1, 20, "disabled");
    wr(OFS_HIGH, 32'h0000_0001);
    wr(OFS_LOW, 32'h0000_0001);
    repeat (3) @(posedge clk);
    rd(OFS_LOW, 32'h0000_0001, "disabled write");
    wr(OFS_SETUP, 32'h0000_0003);
    measure(6, 16'd400, 16'd400, "slow source");
    tally_and_finish();
  end
endmodule // test_fan_led_pwm_generator
`default_nettype wire
